/* File: core/ccd_top.sv */
// Purpose: Holds chipset configuration and applies it to ISA timing, decode and power.
// Assumes: Configuration loads on cfg_we_i; activity inputs are synchronous to clk_i.
// Notes:   Power settings load only while power management is enabled.
module ccd_top #(
    parameter longint MINUTE_CYCLES = ccd_pkg::MINUTE_CYCLES  // Host cycles per minute
)(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Configuration load
    input  wire logic        cfg_we_i,
    input  wire logic        cmd_extra_i,
    input  wire logic        io_recovery_i,
    input  wire logic        decoupled_refresh_i,
    input  wire logic        dma_fast_i,
    input  wire logic        isa_clk_manual_i,
    input  wire logic        mem_hole_i,
    input  wire logic [2:0]  nc1_size_i,
    input  wire logic [11:0] nc1_base_i,
    input  wire logic [2:0]  nc2_size_i,
    input  wire logic [11:0] nc2_base_i,
    input  wire logic [1:0]  cache_timing_i,
    input  wire logic        pm_enable_i,
    input  wire logic        instant_on_i,
    input  wire logic [3:0]  disk_timeout_i,
    input  wire logic [1:0]  video_mode_i,
    // Host access decode
    input  wire logic [31:0] host_addr_i,
    input  wire logic        host_req_i,
    // ISA cycle request
    input  wire logic        isa_io_req_i,
    input  wire logic        isa_refresh_i,
    // Activity and wake
    input  wire logic        disk_access_i,
    input  wire logic        sys_idle_expired_i,
    input  wire logic        wake_i,
    // Decode results
    output logic             to_isa_o,
    output logic             uncacheable_o,
    output logic             dram_stall_o,
    // ISA timing
    output logic             isa_bus_clock_o,
    output logic             dma_clock_o,
    output logic             isa_cmd_o,
    output logic             isa_busy_o,
    // Cache timing and power
    output logic [1:0]       cache_timing_o,
    output logic             disk_standby_o,
    output logic [1:0]       video_state_o,
    output logic             full_power_o
);
    // Stored configuration
    logic        cmd_extra;
    logic        io_recovery;
    logic        decoupled;
    logic        dma_fast;
    logic        clk_manual;
    logic        mem_hole;
    logic [2:0]  nc1_size;
    logic [11:0] nc1_base;
    logic [2:0]  nc2_size;
    logic [11:0] nc2_base;
    logic        pm_en;
    logic        instant_on;
    logic [3:0]  disk_to;
    logic [1:0]  video_sel;
    // ISA clock divider
    logic [3:0]  isa_div;
    logic        isa_tick;      // One-cycle pulse per ISA clock rising edge
    logic        isa_phase;     // Tracks which half period is next
    logic        dma_toggle;
    // ISA sequencer
    ccd_pkg::ccd_isa_state_t isa_state;
    logic [3:0]  isa_cnt;
    // Disk timer
    logic [39:0] minute_cnt;
    logic [3:0]  minutes;

    // Region hit: base aligned by masking below the size
    function automatic logic nc_hit(input logic [2:0] size, input logic [11:0] base,
                                    input logic [31:0] addr);
        logic [15:0] mask;
        logic [15:0] a64k;
        logic [15:0] b64k;
        mask = 16'hFFFF;
        a64k = addr[31:16];
        b64k = {4'h0, base};
        if (size == ccd_pkg::NC_DISABLED)
            return 1'b0;
        mask = 16'hFFFF << (size - 3'h1);
        return ((a64k & mask) == (b64k & mask));
    endfunction : nc_hit

    // Configuration storage with reset defaults
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cmd_extra   <= 1'b0;
            io_recovery <= 1'b0;
            decoupled   <= 1'b0;
            dma_fast    <= 1'b0;
            clk_manual  <= 1'b0;
            mem_hole    <= 1'b0;
            nc1_size    <= ccd_pkg::NC_DISABLED;
            nc1_base    <= 12'h000;
            nc2_size    <= ccd_pkg::NC_DISABLED;
            nc2_base    <= 12'h000;
            cache_timing_o <= ccd_pkg::CACHE_NORMAL;
        end
        else if (cfg_we_i)
        begin
            cmd_extra   <= cmd_extra_i;
            io_recovery <= io_recovery_i;
            decoupled   <= decoupled_refresh_i;
            dma_fast    <= dma_fast_i;
            clk_manual  <= isa_clk_manual_i;
            mem_hole    <= mem_hole_i;
            nc1_size    <= nc1_size_i;
            nc1_base    <= nc1_base_i;
            nc2_size    <= nc2_size_i;
            nc2_base    <= nc2_base_i;
            // Reserved fast and turbo codes fall back to normal
            cache_timing_o <= cache_timing_i[1] ? ccd_pkg::CACHE_NORMAL : cache_timing_i;
        end
    end

    // Power settings: master enable gates loading of the rest
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pm_en      <= 1'b0;
            instant_on <= 1'b0;
            disk_to    <= 4'h0;
            video_sel  <= ccd_pkg::VSEL_DISABLED;
        end
        else if (cfg_we_i)
        begin
            pm_en <= pm_enable_i;
            if (pm_en || pm_enable_i)
            begin
                instant_on <= instant_on_i;
                disk_to    <= disk_timeout_i;
                video_sel  <= video_mode_i;
            end
        end
    end

    // ISA clock divider; manual setting alternates 4 and 3 host cycles
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            isa_div         <= 4'h0;
            isa_phase       <= 1'b0;
            isa_bus_clock_o <= 1'b0;
            isa_tick        <= 1'b0;
        end
        else
        begin
            isa_tick <= 1'b0;
            if (isa_div == 4'h0)
            begin
                // Load the next half period
                if (!clk_manual)
                    isa_div <= ccd_pkg::ISA_HALF_AUTO - 4'h1;
                else if (isa_phase)
                    isa_div <= ccd_pkg::ISA_HALF_MANUAL - 4'h1;
                else
                    isa_div <= ccd_pkg::ISA_HALF_MANUAL_L - 4'h1;
                isa_phase       <= ~isa_phase;
                isa_bus_clock_o <= ~isa_bus_clock_o;
                isa_tick        <= ~isa_bus_clock_o;
            end
            else
                isa_div <= isa_div - 4'h1;
        end
    end

    // DMA clock follows or halves the ISA clock
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dma_toggle  <= 1'b0;
            dma_clock_o <= 1'b0;
        end
        else
        begin
            if (isa_tick)
                dma_toggle <= ~dma_toggle;
            dma_clock_o <= dma_fast ? isa_bus_clock_o : dma_toggle;
        end
    end

    // ISA I/O cycle sequencer, counted in ISA clocks
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            isa_state <= ccd_pkg::ISA_IDLE;
            isa_cnt   <= 4'h0;
            isa_cmd_o <= 1'b0;
        end
        else if (isa_tick)
        begin
            case (isa_state)
                ccd_pkg::ISA_IDLE:
                begin
                    // Start address phase
                    if (isa_io_req_i)
                    begin
                        isa_state <= ccd_pkg::ISA_SETUP;
                        isa_cnt   <= cmd_extra ? ccd_pkg::CMD_DELAY_EXTRA
                                               : ccd_pkg::CMD_DELAY_NORMAL;
                    end
                end
                ccd_pkg::ISA_SETUP:
                begin
                    // Hold off command for setup time
                    if (isa_cnt <= 4'h1)
                    begin
                        isa_state <= ccd_pkg::ISA_CMD;
                        isa_cmd_o <= 1'b1;
                    end
                    else
                        isa_cnt <= isa_cnt - 4'h1;
                end
                ccd_pkg::ISA_CMD:
                begin
                    // Command lasts one ISA clock
                    isa_cmd_o <= 1'b0;
                    isa_cnt   <= ccd_pkg::IO_RECOVERY_CLKS;
                    isa_state <= io_recovery ? ccd_pkg::ISA_RECOVER : ccd_pkg::ISA_IDLE;
                end
                ccd_pkg::ISA_RECOVER:
                begin
                    // Gap before next I/O cycle
                    if (isa_cnt <= 4'h1)
                        isa_state <= ccd_pkg::ISA_IDLE;
                    else
                        isa_cnt <= isa_cnt - 4'h1;
                end
                default:
                    isa_state <= ccd_pkg::ISA_IDLE;
            endcase
        end
    end

    // Busy flag registered for the output
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            isa_busy_o <= 1'b0;
        else
            isa_busy_o <= (isa_state != ccd_pkg::ISA_IDLE);
    end

    // Address decode for hole and regions
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            to_isa_o      <= 1'b0;
            uncacheable_o <= 1'b0;
            dram_stall_o  <= 1'b0;
        end
        else
        begin
            to_isa_o <= host_req_i && mem_hole
                        && (host_addr_i[31:20] == ccd_pkg::HOLE_MB);
            uncacheable_o <= host_req_i
                             && (nc_hit(nc1_size, nc1_base, host_addr_i)
                                 || nc_hit(nc2_size, nc2_base, host_addr_i));
            dram_stall_o <= isa_refresh_i && !decoupled;
        end
    end

    // Disk inactivity timer in whole minutes
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            minute_cnt     <= 40'h0;
            minutes        <= 4'h0;
            disk_standby_o <= 1'b0;
        end
        else if (!pm_en || disk_to == 4'h0 || disk_access_i)
        begin
            // Disabled or activity restarts the count
            minute_cnt     <= 40'h0;
            minutes        <= 4'h0;
            disk_standby_o <= 1'b0;
        end
        else if (!disk_standby_o)
        begin
            if (minute_cnt == 40'(MINUTE_CYCLES - 1))
            begin
                minute_cnt <= 40'h0;
                minutes    <= minutes + 4'h1;
                if (minutes + 4'h1 >= disk_to)
                    disk_standby_o <= 1'b1;
            end
            else
                minute_cnt <= minute_cnt + 40'h1;
        end
    end

    // Video low-power state and return to full power
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            video_state_o <= ccd_pkg::VID_ON;
            full_power_o  <= 1'b1;
        end
        else if (!pm_en || wake_i)
        begin
            video_state_o <= ccd_pkg::VID_ON;
            // Without instant-on the system stays reduced until firmware restores it
            full_power_o  <= !pm_en || instant_on || full_power_o;
        end
        else if (sys_idle_expired_i)
        begin
            full_power_o <= 1'b0;
            case (video_sel)
                ccd_pkg::VSEL_BLANK:   video_state_o <= ccd_pkg::VID_BLANK;
                ccd_pkg::VSEL_STANDBY: video_state_o <= ccd_pkg::VID_STANDBY;
                ccd_pkg::VSEL_OFF:     video_state_o <= ccd_pkg::VID_OFF;
                default:               video_state_o <= ccd_pkg::VID_ON;
            endcase
        end
        else if (cfg_we_i)
            full_power_o <= 1'b1;
    end
endmodule : ccd_top

/* File: core/ccd_pkg.sv */
// Purpose: Constants shared by the chipset configuration and decode block.
// Assumes: 50 MHz host clock, configuration bits arrive as plain ports.
// Notes:   Counts of cycles are derived from times and the clock rate.
// Overview of operation
// - Extra command delay lengthens ISA address setup
// - Recovery gap between consecutive ISA I/O cycles
// - Decoupled refresh lets DRAM run during refresh
// - DMA clock is half or full ISA rate
// - ISA clock about 8 MHz or 7.159 MHz
// - Hole 15-16MB goes to ISA only
// - Two non-cacheable regions, sizes 64KB to 4MB
// - Region base aligned to its own size
// - Accesses inside enabled region are uncacheable
// - Disabled region size marks nothing uncacheable
// - Disk idle timer 1-15 minutes, then standby
// - Video enters chosen low-power state after idle
// - Master enable gates and locks power settings
// - Instant-on returns straight to full power
package ccd_pkg;
    // Host clock rate
    localparam int unsigned CLK_HZ            = 50_000_000;
    // ISA clock half periods in host cycles: 50/(2*3)=8.33 MHz, 50/7 approx 7.14 MHz
    localparam logic [3:0]  ISA_HALF_AUTO     = 4'h3;
    localparam logic [3:0]  ISA_HALF_MANUAL   = 4'h4;
    localparam logic [3:0]  ISA_HALF_MANUAL_L = 4'h3;
    // Command delays in ISA clocks
    localparam logic [3:0]  CMD_DELAY_NORMAL  = 4'h1;
    localparam logic [3:0]  CMD_DELAY_EXTRA   = 4'h3;
    // I/O recovery in ISA clocks
    localparam logic [3:0]  IO_RECOVERY_CLKS  = 4'h4;
    // One minute in host cycles
    localparam int unsigned MINUTE_S          = 60;
    localparam longint      MINUTE_CYCLES     = longint'(MINUTE_S) * CLK_HZ;
    // Memory hole bounds in 1MB units of the address
    localparam logic [11:0] HOLE_MB           = 12'h00F;
    // Region size codes
    localparam logic [2:0]  NC_DISABLED       = 3'h0;
    // Smallest region size is 2^16 bytes
    localparam int unsigned NC_MIN_SHIFT      = 16;
    // Cache timing codes; normal is the reset value
    localparam logic [1:0]  CACHE_NORMAL      = 2'h0;
    localparam logic [1:0]  CACHE_MEDIUM      = 2'h1;
    // Video low-power states
    typedef enum logic [1:0]
    {
        VID_ON      = 2'h0,
        VID_BLANK   = 2'h1,
        VID_STANDBY = 2'h3,
        VID_OFF     = 2'h2
    } ccd_video_t;
    // Video selection codes
    localparam logic [1:0]  VSEL_DISABLED     = 2'h0;
    localparam logic [1:0]  VSEL_BLANK        = 2'h1;
    localparam logic [1:0]  VSEL_STANDBY      = 2'h2;
    localparam logic [1:0]  VSEL_OFF          = 2'h3;
    // ISA cycle sequencer states, Gray along the path through recovery; CMD straight to IDLE flips both bits
    typedef enum logic [1:0]
    {
        ISA_IDLE    = 2'h0,
        ISA_SETUP   = 2'h1,
        ISA_CMD     = 2'h3,
        ISA_RECOVER = 2'h2
    } ccd_isa_state_t;
endpackage : ccd_pkg

/* File: verif/ccd_checker.sv */
// Purpose: Port assertions for the chipset configuration and decode block.
// Assumes: Shadow copies of the settings follow cfg_we_i; addresses stay below 256MB.
// Notes:   Clock and command shapes are checked in the automatic clock setting only.
module ccd_checker (
    // Clock, reset and load
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        cfg_we_i,
    // Settings
    input wire logic        mem_hole_i,
    input wire logic        decoupled_refresh_i,
    input wire logic        dma_fast_i,
    input wire logic        isa_clk_manual_i,
    input wire logic [2:0]  nc1_size_i,
    input wire logic [11:0] nc1_base_i,
    input wire logic [2:0]  nc2_size_i,
    input wire logic [11:0] nc2_base_i,
    input wire logic        pm_enable_i,
    input wire logic        instant_on_i,
    input wire logic [1:0]  video_mode_i,
    // Activity
    input wire logic [31:0] host_addr_i,
    input wire logic        host_req_i,
    input wire logic        isa_refresh_i,
    input wire logic        sys_idle_expired_i,
    input wire logic        wake_i,
    // Outputs watched
    input wire logic        to_isa_o,
    input wire logic        uncacheable_o,
    input wire logic        dram_stall_o,
    input wire logic        isa_bus_clock_o,
    input wire logic        dma_clock_o,
    input wire logic        isa_cmd_o,
    input wire logic [1:0]  video_state_o,
    input wire logic        full_power_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        hole, dec, fast, man, pm, inst;  // Stored flags
    logic [1:0]  vsel;                            // Stored video choice
    logic [2:0]  s1, s2;                          // Stored region sizes
    logic [11:0] b1, b2;                          // Stored region bases
    logic        hole_x, nc_x, stall_x;           // Expected decode results

    // Region hit: low base bits under the size are ignored
    function automatic logic hit(input logic [2:0] s, input logic [11:0] b,
                                 input logic [31:0] a);
        return (s != 3'h0) && (a[31:28] == 4'h0)
            && (((a[27:16] ^ b) & (12'hFFF << (s - 3'h1))) == 12'h000);
    endfunction : hit

    // Shadow of the stored configuration; power fields need power management on
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            {hole, dec, fast, man, pm, inst, vsel, s1, s2, b1, b2} <= '0;
        else if (cfg_we_i)
        begin
            {hole, dec, fast, man} <= {mem_hole_i, decoupled_refresh_i, dma_fast_i,
                                       isa_clk_manual_i};
            {pm, s1, b1, s2, b2}   <= {pm_enable_i, nc1_size_i, nc1_base_i, nc2_size_i,
                                       nc2_base_i};
            if (pm || pm_enable_i)
                {inst, vsel} <= {instant_on_i, video_mode_i};
        end
    end

    assign hole_x  = host_req_i && hole && (host_addr_i[31:20] == 12'h00F);
    assign nc_x    = host_req_i && (hit(s1, b1, host_addr_i) || hit(s2, b2, host_addr_i));
    assign stall_x = rst_n_i && isa_refresh_i && !dec;

    property p_hole;
        @(posedge clk_i) disable iff (!rst_n_i) to_isa_o == $past(hole_x);
    endproperty
    a_hole: assert property (p_hole) else $error("hole decode wrong");
    property p_nc;
        @(posedge clk_i) disable iff (!rst_n_i) uncacheable_o == $past(nc_x);
    endproperty
    a_nc: assert property (p_nc) else $error("region decode wrong");
    property p_stall;
        @(posedge clk_i) disable iff (!rst_n_i) dram_stall_o == $past(stall_x);
    endproperty
    a_stall: assert property (p_stall) else $error("refresh stall wrong");
    property p_isaclk;
        @(posedge clk_i) disable iff (!rst_n_i)
        !man && $rose(isa_bus_clock_o) |-> isa_bus_clock_o [*3] ##1 !isa_bus_clock_o;
    endproperty
    a_isaclk: assert property (p_isaclk) else $error("bus clock half period wrong");
    property p_cmd;
        @(posedge clk_i) disable iff (!rst_n_i)
        !man && $rose(isa_cmd_o) |-> isa_cmd_o [*6] ##1 !isa_cmd_o;
    endproperty
    a_cmd: assert property (p_cmd) else $error("command length wrong");
    property p_dma;
        @(posedge clk_i) disable iff (!rst_n_i)
        fast && $past(fast) |-> dma_clock_o == $past(isa_bus_clock_o);
    endproperty
    a_dma: assert property (p_dma) else $error("fast dma clock wrong");
    property p_video;
        @(posedge clk_i) disable iff (!rst_n_i)
        pm && sys_idle_expired_i && !wake_i && !cfg_we_i
        |=> video_state_o == {vsel[1], ^vsel} && !full_power_o;
    endproperty
    a_video: assert property (p_video) else $error("video state wrong");
    property p_instant;
        @(posedge clk_i) disable iff (!rst_n_i)
        pm && inst && wake_i && !cfg_we_i |=> full_power_o && video_state_o == 2'h0;
    endproperty
    a_instant: assert property (p_instant) else $error("instant on failed");
    property p_pmoff;
        @(posedge clk_i) disable iff (!rst_n_i)
        !pm && !$past(pm) |-> video_state_o == 2'h0 && full_power_o;
    endproperty
    a_pmoff: assert property (p_pmoff) else $error("power off not forced");
endmodule : ccd_checker

bind ccd_top ccd_checker u_chk (.*);

/* File: verif/ccd_isa_dev.sv */
// Purpose: ISA device model that asks for I/O cycles.
// Assumes: A request is held until the command strobe answers it.
// Notes:   Re-requests right after each command to provoke back-to-back cycles.
module ccd_isa_dev (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Demand and bus
    input  wire logic [3:0] want_i,
    input  wire logic       isa_cmd_i,
    output logic            isa_io_req_o,
    output logic [3:0]      done_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Requests until done count meets demand
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            {isa_io_req_o, done_o} <= '0;
        else if (isa_cmd_i && isa_io_req_o)
            {isa_io_req_o, done_o} <= {1'b0, done_o + 4'h1};
        else if (!isa_cmd_i)
            isa_io_req_o <= (done_o != want_i);
    end
endmodule : ccd_isa_dev

/* File: verif/tb_ccd_top.sv */
// Purpose: Self-checking bench for the chipset configuration and decode block.
// Assumes: Inputs change at the falling edge; a minute is shortened to 20 cycles.
// Notes:   Manual bus clock is chosen last and kept to the end.
module tb_ccd_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam longint     MIN_CYC = 20;
    localparam logic [1:0] VMAP[4] = '{ccd_pkg::VID_ON, ccd_pkg::VID_BLANK,
                                       ccd_pkg::VID_STANDBY, ccd_pkg::VID_OFF};
    logic        clk_i, rst_n_i, cfg_we_i, cmd_extra_i, io_recovery_i, mem_hole_i;
    logic        decoupled_refresh_i, dma_fast_i, isa_clk_manual_i, pm_enable_i;
    logic [2:0]  nc1_size_i, nc2_size_i;
    logic [11:0] nc1_base_i, nc2_base_i;
    logic [1:0]  cache_timing_i, video_mode_i, cache_timing_o, video_state_o;
    logic        instant_on_i, host_req_i, isa_io_req_i, isa_refresh_i, disk_access_i;
    logic [3:0]  disk_timeout_i, want, done;
    logic [31:0] host_addr_i, start, sz;
    logic        sys_idle_expired_i, wake_i, to_isa_o, uncacheable_o, dram_stall_o;
    logic        isa_bus_clock_o, dma_clock_o, isa_cmd_o, isa_busy_o, disk_standby_o;
    logic        full_power_o, cmd_d, isa_d, dma_d;
    int          error_cnt, total_checks, gap, run, nisa, ndma, a, b;

    ccd_top #(.MINUTE_CYCLES(MIN_CYC)) uut (.*);
    ccd_isa_dev dev (.clk_i(clk_i), .rst_n_i(rst_n_i), .want_i(want), .isa_cmd_i(isa_cmd_o),
                     .isa_io_req_o(isa_io_req_i), .done_o(done));

    // Host clock, 20 ns
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // Samples 5 ns after each rising edge: command gaps and clock rising edges
    always @(posedge clk_i)
    begin
        #5;
        if (isa_cmd_o && !cmd_d)
            gap = run;
        run = isa_cmd_o ? 0 : run + 1;
        nisa += int'(isa_bus_clock_o && !isa_d);
        ndma += int'(dma_clock_o && !dma_d);
        {cmd_d, isa_d, dma_d} = {isa_cmd_o, isa_bus_clock_o, dma_clock_o};
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Load pulse, then one cycle for the effect
    task automatic cfg;
        @(negedge clk_i) cfg_we_i = 1'b1;
        @(negedge clk_i) cfg_we_i = 1'b0;
        @(negedge clk_i);
    endtask : cfg

    // One host access, decode seen a cycle later
    task automatic host(input logic [31:0] ad, input logic ei, input logic en);
        @(negedge clk_i) {host_req_i, host_addr_i} = {1'b1, ad};
        @(negedge clk_i) host_req_i = 1'b0;
        chk({to_isa_o, uncacheable_o}, {ei, en});
    endtask : host

    // Idle expiry or wake pulse
    task automatic pulse(input logic wk);
        @(negedge clk_i) {wake_i, sys_idle_expired_i} = {wk, !wk};
        @(negedge clk_i) {wake_i, sys_idle_expired_i} = 2'b00;
        @(negedge clk_i);
    endtask : pulse

    task automatic close_out;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out

    // Watchdog, well beyond the expected run
    initial
    begin
        #400000;
        error_cnt++;
        close_out();
    end

    initial
    begin
        {cfg_we_i, cmd_extra_i, io_recovery_i, decoupled_refresh_i, dma_fast_i} = '0;
        {isa_clk_manual_i, mem_hole_i, nc1_size_i, nc2_size_i, nc1_base_i} = '0;
        {nc2_base_i, cache_timing_i, video_mode_i, pm_enable_i, instant_on_i} = '0;
        {host_req_i, isa_refresh_i, disk_timeout_i, want, host_addr_i, disk_access_i} = '0;
        {sys_idle_expired_i, wake_i, error_cnt, total_checks, gap, run, nisa, ndma} = '0;
        rst_n_i = 1'b0;
        repeat (3) @(negedge clk_i);
        rst_n_i = 1'b1;
        @(negedge clk_i);
        chk({cache_timing_o, video_state_o, full_power_o, disk_standby_o}, 6'h02);
        host(32'h00F0_0000, 1'b0, 1'b0);
        mem_hole_i = 1'b1;
        cfg();
        host(32'h00F0_0000, 1'b1, 1'b0);
        host(32'h00FF_FFFC, 1'b1, 1'b0);
        host(32'h00EF_FFFC, 1'b0, 1'b0);
        host(32'h0100_0000, 1'b0, 1'b0);
        $display("hole test done");
        // Every region size on base 07F, misaligned for all but 64KB; second region disabled
        {nc1_base_i, nc2_base_i} = {12'h07F, 12'h07F};
        for (int s = 1; s < 8; s++)
        begin
            nc1_size_i = 3'(s);
            cfg();
            sz    = 32'h0001_0000 << (s - 1);
            start = 32'h007F_0000 & ~(sz - 32'h1);
            host(start + sz - 32'h1, 1'b0, 1'b1);
            host(start + sz, 1'b0, 1'b0);
            host(start - 32'h1, 1'b0, 1'b0);
        end
        {nc1_size_i, nc2_size_i, nc2_base_i} = {3'h0, 3'h1, 12'h000};
        cfg();
        host(32'h007F_0000, 1'b0, 1'b0);
        host(32'h0000_FFFF, 1'b0, 1'b1);
        host(32'h0001_0000, 1'b0, 1'b0);
        $display("region test done");
        isa_refresh_i = 1'b1;
        for (int d = 0; d < 2; d++)
        begin
            decoupled_refresh_i = d[0];
            cfg();
            chk(dram_stall_o, !d[0]);
        end
        isa_refresh_i = 1'b0;
        for (int c = 0; c < 4; c++)
        begin
            cache_timing_i = 2'(c);
            cfg();
            chk(cache_timing_o, c < 2 ? c : 0);
        end
        $display("refresh and cache test done");
        // Spacing of back-to-back cycles: plain, extra delay, recovery
        for (int m = 0; m < 3; m++)
        begin
            {io_recovery_i, cmd_extra_i} = 2'(m);
            cfg();
            want = done + 4'h2;
            for (a = 0; a < 300 && done != want; a++)
                @(negedge clk_i);
            chk(done, want);
            chk(isa_busy_o, 1'b1);
            chk(gap >= 6 + 12 * m && gap <= 18 + 12 * m, 1'b1);
        end
        $display("isa cycle test done");
        for (int k = 0; k < 3; k++)
        begin
            {isa_clk_manual_i, dma_fast_i} = {k == 2, k == 1};
            cfg();
            repeat (14) @(negedge clk_i);
            {a, b} = {nisa, ndma};
            repeat (840) @(negedge clk_i);
            chk(nisa - a, k == 2 ? 120 : 140);
            chk(ndma - b, k == 0 ? 70 : (k == 1 ? 140 : 60));
        end
        chk(isa_busy_o, 1'b0);
        $display("clock test done");
        video_mode_i = 2'h1;
        cfg();
        pulse(1'b0);
        chk({video_state_o, full_power_o}, 3'h1);
        {pm_enable_i, instant_on_i} = 2'b11;
        for (int v = 0; v < 4; v++)
        begin
            video_mode_i = 2'(v);
            cfg();
            pulse(1'b0);
            chk({video_state_o, full_power_o}, {VMAP[v], 1'b0});
            pulse(1'b1);
            chk({video_state_o, full_power_o}, 3'h1);
        end
        instant_on_i = 1'b0;
        cfg();
        pulse(1'b0);
        pulse(1'b1);
        chk(full_power_o, 1'b0);
        disk_timeout_i = 4'h2;
        cfg();
        @(negedge clk_i) disk_access_i = 1'b1;
        @(negedge clk_i) disk_access_i = 1'b0;
        repeat (2 * MIN_CYC - 4) @(negedge clk_i);
        chk(disk_standby_o, 1'b0);
        repeat (8) @(negedge clk_i);
        chk(disk_standby_o, 1'b1);
        @(negedge clk_i) disk_access_i = 1'b1;
        @(negedge clk_i) disk_access_i = 1'b0;
        chk(disk_standby_o, 1'b0);
        pm_enable_i = 1'b0;
        cfg();
        pulse(1'b0);
        chk({video_state_o, full_power_o}, 3'h1);
        $display("power test done");
        close_out();
    end
endmodule : tb_ccd_top
